/* verilog/terminal_decoder_pkg.sv */
// Constants for the input terminal function decoder.
// Assumes a 100 MHz system clock and a plain strobe register port.
// Functional notes
// - Four speed terminals form a 4-bit stage selector; all ON picks stage 15.
// - Up terminal raises, down terminal lowers set frequency when up/down is source.
// - Two ramp select terminals form a 2-bit code; both OFF picks set one.
// - PID pause terminal active holds PID adjustment and present output frequency.
// - Gain switch condition 1: terminal off uses first set, on uses second.
// - Counter trigger terminal pulses are counted up to 50 Hz; count survives power loss.
// - Counter reset terminal clears the pulse counter to zero.
// - Length reset terminal active clears the actual length value.
// - Ramp prohibition holds present speed, ignores speed changes, not during jog.
// - Immediate DC brake terminal starts DC braking while decelerating in DC stop mode.
// - Up/down clear terminal resets the up/down frequency when up/down is source.
// - Codes 28, 29, 30 switch command source to keypad, terminals, communication.
// - Several source switches together: keypad first, then terminals, then communication.
package terminal_decoder_pkg;
   localparam int          NUM_TERM       = 5;
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          DEBOUNCE_US    = 2000;
   localparam int          DEBOUNCE_CYC   = DEBOUNCE_US * 1000 / CLK_PERIOD_NS;
   localparam int          UPDN_STEP_US   = 1000;
   localparam int          UPDN_STEP_CYC  = UPDN_STEP_US * 1000 / CLK_PERIOD_NS;
   localparam logic [15:0] UPDN_MAX       = 16'hffff;

   // Register offsets
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_FUNC_BASE  = 8'h04;
   localparam logic [7:0]  OFS_COUNT      = 8'h20;
   localparam logic [7:0]  OFS_STATUS     = 8'h24;
   localparam logic [7:0]  OFS_UPDN       = 8'h28;

   // Control fields
   localparam int          CTRL_UPDN_SRC  = 0;
   localparam int          CTRL_DC_STOP   = 1;
   localparam int          CTRL_PIDSW_LSB = 2;
   localparam logic [1:0]  PIDSW_TERMINAL = 2'h1;
   localparam logic [3:0]  CTRL_RESET     = 4'h0;
   localparam logic [4:0]  FUNC_RESET     = 5'h00;

   // Terminal function codes
   localparam logic [4:0]  FN_UP          = 5'd10;
   localparam logic [4:0]  FN_DOWN        = 5'd11;
   localparam logic [4:0]  FN_MS1         = 5'd12;
   localparam logic [4:0]  FN_RAMP1       = 5'd16;
   localparam logic [4:0]  FN_PID_PAUSE   = 5'd20;
   localparam logic [4:0]  FN_PID_SWITCH  = 5'd21;
   localparam logic [4:0]  FN_CNT_TRIG    = 5'd22;
   localparam logic [4:0]  FN_CNT_CLEAR   = 5'd23;
   localparam logic [4:0]  FN_LEN_CLEAR   = 5'd24;
   localparam logic [4:0]  FN_RAMP_HOLD   = 5'd25;
   localparam logic [4:0]  FN_DC_NOW      = 5'd26;
   localparam logic [4:0]  FN_UPDN_CLEAR  = 5'd27;
   localparam logic [4:0]  FN_SRC_KEYPAD  = 5'd28;
   localparam logic [4:0]  FN_SRC_TERM    = 5'd29;
   localparam logic [4:0]  FN_SRC_COMM    = 5'd30;

   typedef enum logic [1:0] {SRC_KEYPAD, SRC_TERMINAL, SRC_COMM} cmd_src_e;
endpackage

/* verilog/input_terminal_function_decoder.sv */
// Decodes debounced multifunction input terminals into drive control actions.
// Assumes terminals and core status are synchronous to clk_sys; firmware
// saves and restores the pulse count around power loss via its register.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
module input_terminal_function_decoder
   import terminal_decoder_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
   parameter int UPDN_CYCLES     = UPDN_STEP_CYC
) (
   input  wire logic                clk_sys,
   input  wire logic                resetn,
   input  wire logic [NUM_TERM-1:0] terminalIn,
   input  wire logic                jogActive,
   input  wire logic                decelerating,
   input  wire logic [7:0]          regAddr,
   input  wire logic [31:0]         regWdata,
   input  wire logic                regWr,
   input  wire logic                regRd,
   output logic [31:0]              regRdata,
   output logic [3:0]               speedStage,
   output logic [1:0]               rampSet,
   output logic                     pidHold,
   output logic                     pidGainSecond,
   output logic [15:0]              pulseCount,
   output logic                     lengthClear,
   output logic                     rampFreeze,
   output logic                     dcBrakeNow,
   output logic [15:0]              updnFreq,
   output logic [1:0]               cmdSource
);

   // Any terminal assigned code c and currently ON
   function automatic logic fnOn(input logic [NUM_TERM-1:0][4:0] sel,
                                 input logic [NUM_TERM-1:0]      lvl,
                                 input logic [4:0]               c);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NUM_TERM; i++) begin
         if (lvl[i] && sel[i] == c) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   logic [NUM_TERM-1:0][4:0] funcSel_q;
   logic [3:0]               ctrl_q;
   logic [NUM_TERM-1:0]      termSync_q;
   logic [NUM_TERM-1:0]      termLevel_q;
   logic                     trigPrev_q;
   logic [31:0]              updnCnt_q;
   logic [15:0]              pulseCount_q;
   logic [15:0]              updnFreq_q;
   logic [31:0]              regRdata_q;
   logic [3:0]               speedStage_q;
   logic [1:0]               rampSet_q;
   logic                     pidHold_q;
   logic                     pidGainSecond_q;
   logic                     lengthClear_q;
   logic                     rampFreeze_q;
   logic                     dcBrakeNow_q;
   logic [1:0]               cmdSource_q;

   logic                     fUp;
   logic                     fDown;
   logic                     fTrig;
   logic                     fCntClr;
   logic                     fUpdnClr;
   logic                     freezeNow;
   logic                     stepTick;
   logic                     countWr;
   logic [3:0]               msCode;

   // Input sampling and debounce, one filter per terminal
   genvar g;
   generate
      for (g = 0; g < NUM_TERM; g++) begin : gDeb
         logic [31:0] stable_q;
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               termSync_q[g]  <= 1'b0;
               termLevel_q[g] <= 1'b0;
               stable_q       <= 32'h0;
            end else begin
               termSync_q[g] <= terminalIn[g];
               // Level accepted only after it stays put; bounce restarts the wait
               if (termSync_q[g] == termLevel_q[g]) begin
                  stable_q <= 32'h0;
               end else if (stable_q >= 32'(DEBOUNCE_CYCLES - 1)) begin
                  stable_q       <= 32'h0;
                  termLevel_q[g] <= termSync_q[g];
               end else begin
                  stable_q <= stable_q + 32'h1;
               end
            end
         end
      end
   endgenerate

   assign fUp       = fnOn(funcSel_q, termLevel_q, FN_UP);
   assign fDown     = fnOn(funcSel_q, termLevel_q, FN_DOWN);
   assign fTrig     = fnOn(funcSel_q, termLevel_q, FN_CNT_TRIG);
   assign fCntClr   = fnOn(funcSel_q, termLevel_q, FN_CNT_CLEAR);
   assign fUpdnClr  = fnOn(funcSel_q, termLevel_q, FN_UPDN_CLEAR);
   assign freezeNow = fnOn(funcSel_q, termLevel_q, FN_RAMP_HOLD) && !jogActive;
   assign stepTick  = (updnCnt_q >= 32'(UPDN_CYCLES - 1));
   assign countWr   = regWr && regAddr == OFS_COUNT;

   always_comb begin
      msCode = 4'h0;
      for (int b = 0; b < 4; b++) begin
         msCode[b] = fnOn(funcSel_q, termLevel_q, FN_MS1 + 5'(b));
      end
   end

   // Register writes
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl_q    <= CTRL_RESET;
         funcSel_q <= {NUM_TERM{FUNC_RESET}};
      end else if (regWr) begin
         if (regAddr == OFS_CTRL) begin
            ctrl_q <= regWdata[3:0];
         end
         for (int i = 0; i < NUM_TERM; i++) begin
            if (regAddr == OFS_FUNC_BASE + 8'(4 * i)) begin
               funcSel_q[i] <= regWdata[4:0];
            end
         end
      end
   end

   // Pulse counter: clear beats restore, restore beats a count
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         trigPrev_q   <= 1'b0;
         pulseCount_q <= 16'h0;
      end else begin
         trigPrev_q <= fTrig;
         if (fCntClr) begin
            pulseCount_q <= 16'h0;
         end else if (countWr) begin
            pulseCount_q <= regWdata[15:0];
         end else if (fTrig && !trigPrev_q) begin
            pulseCount_q <= pulseCount_q + 16'h1;
         end
      end
   end

   // Up/down frequency accumulator, stepped at a fixed rate
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         updnCnt_q  <= 32'h0;
         updnFreq_q <= 16'h0;
      end else begin
         updnCnt_q <= stepTick ? 32'h0 : updnCnt_q + 32'h1;
         if (ctrl_q[CTRL_UPDN_SRC]) begin
            if (fUpdnClr) begin
               updnFreq_q <= 16'h0;
            end else if (stepTick && !freezeNow) begin
               // Both terminals ON cancel out
               if (fUp && !fDown && updnFreq_q != UPDN_MAX) begin
                  updnFreq_q <= updnFreq_q + 16'h1;
               end else if (fDown && !fUp && updnFreq_q != 16'h0) begin
                  updnFreq_q <= updnFreq_q - 16'h1;
               end
            end
         end
      end
   end

   // Speed, ramp and PID controls
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         speedStage_q    <= 4'h0;
         rampSet_q       <= 2'h0;
         pidHold_q       <= 1'b0;
         pidGainSecond_q <= 1'b0;
         lengthClear_q   <= 1'b0;
         rampFreeze_q    <= 1'b0;
         dcBrakeNow_q    <= 1'b0;
      end else begin
         // Stage stays put while frozen, so speed cannot be changed
         if (!freezeNow) begin
            speedStage_q <= msCode;
         end
         rampSet_q[0]    <= fnOn(funcSel_q, termLevel_q, FN_RAMP1);
         rampSet_q[1]    <= fnOn(funcSel_q, termLevel_q, FN_RAMP1 + 5'h1);
         pidHold_q       <= fnOn(funcSel_q, termLevel_q, FN_PID_PAUSE);
         pidGainSecond_q <= (ctrl_q[CTRL_PIDSW_LSB +: 2] == PIDSW_TERMINAL)
                            && fnOn(funcSel_q, termLevel_q, FN_PID_SWITCH);
         lengthClear_q   <= fnOn(funcSel_q, termLevel_q, FN_LEN_CLEAR);
         rampFreeze_q    <= freezeNow;
         dcBrakeNow_q    <= decelerating && ctrl_q[CTRL_DC_STOP]
                            && fnOn(funcSel_q, termLevel_q, FN_DC_NOW);
      end
   end

   // Command source: last selection held until another switch terminal is ON
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cmdSource_q <= SRC_KEYPAD;
      end else if (fnOn(funcSel_q, termLevel_q, FN_SRC_KEYPAD)) begin
         cmdSource_q <= SRC_KEYPAD;
      end else if (fnOn(funcSel_q, termLevel_q, FN_SRC_TERM)) begin
         cmdSource_q <= SRC_TERMINAL;
      end else if (fnOn(funcSel_q, termLevel_q, FN_SRC_COMM)) begin
         cmdSource_q <= SRC_COMM;
      end
   end

   // Read data, valid the cycle after the strobe only
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         regRdata_q <= 32'h0;
      end else begin
         regRdata_q <= 32'h0;
         if (regRd) begin
            if (regAddr == OFS_CTRL) begin
               regRdata_q <= {28'h0, ctrl_q};
            end
            for (int i = 0; i < NUM_TERM; i++) begin
               if (regAddr == OFS_FUNC_BASE + 8'(4 * i)) begin
                  regRdata_q <= {27'h0, funcSel_q[i]};
               end
            end
            if (regAddr == OFS_COUNT) begin
               regRdata_q <= {16'h0, pulseCount_q};
            end
            if (regAddr == OFS_STATUS) begin
               regRdata_q <= {11'h0, cmdSource_q, dcBrakeNow_q, rampFreeze_q,
                              lengthClear_q, pidGainSecond_q, pidHold_q, rampSet_q,
                              speedStage_q, 3'h0, termLevel_q};
            end
            if (regAddr == OFS_UPDN) begin
               regRdata_q <= {16'h0, updnFreq_q};
            end
         end
      end
   end

   assign regRdata      = regRdata_q;
   assign speedStage    = speedStage_q;
   assign rampSet       = rampSet_q;
   assign pidHold       = pidHold_q;
   assign pidGainSecond = pidGainSecond_q;
   assign pulseCount    = pulseCount_q;
   assign lengthClear   = lengthClear_q;
   assign rampFreeze    = rampFreeze_q;
   assign dcBrakeNow    = dcBrakeNow_q;
   assign updnFreq      = updnFreq_q;
   assign cmdSource     = cmdSource_q;

endmodule

/* bench/terminal_decoder_checker.sv */
// Port-level properties of the terminal decoder.
// Assumes it is bound to the decoder top and sees its ports only.
`timescale 1ns/1ps
module terminal_decoder_checker
   import terminal_decoder_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        resetn,
   input wire logic        decelerating,
   input wire logic [7:0]  regAddr,
   input wire logic        regRd,
   input wire logic        regWr,
   input wire logic [31:0] regRdata,
   input wire logic [3:0]  speedStage,
   input wire logic [15:0] pulseCount,
   input wire logic        rampFreeze,
   input wire logic        dcBrakeNow,
   input wire logic [15:0] updnFreq,
   input wire logic [1:0]  cmdSource
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   chk_stage_frozen: assert property (rampFreeze && $past(rampFreeze) |-> $stable(speedStage))
      else $error("stage moved while frozen");
   chk_updn_frozen: assert property (rampFreeze && $past(rampFreeze) |-> $stable(updnFreq))
      else $error("up/down moved while frozen");
   chk_dc_needs_decel: assert property (dcBrakeNow |-> decelerating || $past(decelerating))
      else $error("dc brake without deceleration");
   chk_count_one_step: assert property (!$past(regWr) && $changed(pulseCount)
      |-> pulseCount == $past(pulseCount) + 16'h1 || pulseCount == 16'h0)
      else $error("count jumped");
   chk_updn_one_step: assert property ($changed(updnFreq) |-> updnFreq == 16'h0
      || updnFreq == $past(updnFreq) + 16'h1 || updnFreq == $past(updnFreq) - 16'h1)
      else $error("up/down jumped");
   chk_src_legal: assert property (cmdSource != 2'h3)
      else $error("illegal command source");
   chk_count_read: assert property ($past(regRd) && $past(regAddr) == OFS_COUNT
      |-> regRdata == {16'h0, $past(pulseCount)})
      else $error("count read mismatch");
   chk_status_read: assert property ($past(regRd) && $past(regAddr) == OFS_STATUS
      |-> regRdata[11:8] == $past(speedStage) && regRdata[20:19] == $past(cmdSource))
      else $error("status read mismatch");
endmodule

/* bench/terminal_switch_model.sv */
// Switches and controller outputs wired to the input terminals.
// Assumes bench requests; pulses outlast debounce so the rate stays legal.
`timescale 1ns/1ps
module terminal_switch_model #(
   parameter int HOLD = 10
) (
   input  wire logic       clk_sys,
   input  wire logic [4:0] swReq,
   output logic      [4:0] terminalIn = 5'h00
);
   logic [4:0] pulseLvl = 5'h00;
   always @(posedge clk_sys) begin
      terminalIn <= swReq | pulseLvl;
   end
   task automatic pulse(input int idx);
      pulseLvl[idx] <= 1'b1;
      repeat (HOLD) @(posedge clk_sys);
      pulseLvl[idx] <= 1'b0;
      repeat (HOLD) @(posedge clk_sys);
   endtask
endmodule

/* bench/input_terminal_function_decoder_tb.sv */
// Bench for the terminal decoder, one task per scenario.
// Assumes short debounce and step counts to keep the run small.
`timescale 1ns/1ps
module input_terminal_function_decoder_tb;
   import terminal_decoder_pkg::*;
   localparam int DEB = 4;
   localparam int STEP = 8;
   localparam int SETTLE = DEB + 6;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [4:0] swReq = 5'h00;
   logic jogActive = 1'b0;
   logic decelerating = 1'b0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic [4:0] terminalIn;
   logic [31:0] regRdata;
   logic [15:0] pulseCount, updnFreq;
   logic [3:0] speedStage;
   logic [1:0] rampSet, cmdSource;
   logic pidHold, pidGainSecond, lengthClear, rampFreeze, dcBrakeNow;
   int fails = 0;
   int nTests = 0;
   int cyc = 0;
   terminal_switch_model #(.HOLD(SETTLE)) i_sw (.clk_sys(clk_sys), .swReq(swReq),
      .terminalIn(terminalIn));
   input_terminal_function_decoder #(.DEBOUNCE_CYCLES(DEB), .UPDN_CYCLES(STEP)) i_dut (
      .clk_sys(clk_sys), .resetn(resetn), .terminalIn(terminalIn), .jogActive(jogActive),
      .decelerating(decelerating), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .speedStage(speedStage), .rampSet(rampSet),
      .pidHold(pidHold), .pidGainSecond(pidGainSecond), .pulseCount(pulseCount),
      .lengthClear(lengthClear), .rampFreeze(rampFreeze), .dcBrakeNow(dcBrakeNow),
      .updnFreq(updnFreq), .cmdSource(cmdSource));
   initial forever #5 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 chk(regRdata, exp);
   endtask
   // Five codes packed low terminal first
   task automatic fnAll(input logic [24:0] c);
      for (int i = 0; i < 5; i++) wr(OFS_FUNC_BASE + 8'(4 * i), {27'h0, c[5*i+:5]});
   endtask
   task automatic sw(input logic [4:0] v);
      swReq <= v;
      repeat (SETTLE) @(posedge clk_sys);
   endtask
   task automatic t_stage();
      fnAll({5'h0, FN_MS1 + 5'd3, FN_MS1 + 5'd2, FN_MS1 + 5'd1, FN_MS1});
      for (int b = 0; b < 4; b++) begin
         sw(5'(1 << b));
         chk({28'h0, speedStage}, 32'(1 << b));
      end
      sw(5'h0f);
      chk({28'h0, speedStage}, 32'hf);
      rdChk(OFS_STATUS, 32'h00000f0f);
      sw(5'h00);
      $display("t_stage done");
   endtask
   task automatic t_ramp_pid();
      fnAll({15'h0, FN_RAMP1 + 5'd1, FN_RAMP1});
      for (int c = 0; c < 4; c++) begin
         sw(5'(c));
         chk({30'h0, rampSet}, 32'(c));
      end
      wr(OFS_CTRL, {28'h0, PIDSW_TERMINAL, 2'h0});
      fnAll({15'h0, FN_PID_SWITCH, FN_PID_PAUSE});
      sw(5'h01);
      chk({30'h0, pidHold, pidGainSecond}, 32'h2);
      sw(5'h03);
      chk({30'h0, pidHold, pidGainSecond}, 32'h3);
      // Condition other than terminal: second set must drop out
      wr(OFS_CTRL, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk({30'h0, pidHold, pidGainSecond}, 32'h2);
      sw(5'h00);
      chk({30'h0, pidHold, pidGainSecond}, 32'h0);
      $display("t_ramp_pid done");
   endtask
   task automatic t_count();
      fnAll({15'h0, FN_CNT_CLEAR, FN_CNT_TRIG});
      repeat (3) i_sw.pulse(0);
      chk({16'h0, pulseCount}, 32'h3);
      wr(OFS_COUNT, 32'h1234);
      rdChk(OFS_COUNT, 32'h1234);
      sw(5'h02);
      chk({16'h0, pulseCount}, 32'h0);
      sw(5'h00);
      $display("t_count done");
   endtask
   task automatic t_brake();
      wr(OFS_CTRL, 32'h2);
      decelerating <= 1'b1;
      fnAll({5'h0, FN_MS1, FN_DC_NOW, FN_RAMP_HOLD, FN_LEN_CLEAR});
      sw(5'h07);
      chk({29'h0, lengthClear, rampFreeze, dcBrakeNow}, 32'h7);
      // Brake terminal alone is not enough outside DC stop mode
      wr(OFS_CTRL, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, dcBrakeNow}, 32'h0);
      wr(OFS_CTRL, 32'h2);
      sw(5'h0f);
      chk({28'h0, speedStage}, 32'h0);
      jogActive <= 1'b1;
      decelerating <= 1'b0;
      repeat (SETTLE) @(posedge clk_sys);
      chk({27'h0, rampFreeze, speedStage}, 32'h1);
      chk({31'h0, dcBrakeNow}, 32'h0);
      jogActive <= 1'b0;
      sw(5'h00);
      $display("t_brake done");
   endtask
   task automatic t_updn();
      wr(OFS_CTRL, 32'h1);
      fnAll({5'h0, FN_RAMP_HOLD, FN_UPDN_CLEAR, FN_DOWN, FN_UP});
      sw(5'h01);
      repeat (STEP * 4) @(posedge clk_sys);
      chk(32'(updnFreq >= 16'd3 && updnFreq <= 16'd7), 32'h1);
      // Enough down steps to walk any reachable value back to zero
      sw(5'h02);
      repeat (STEP * 8) @(posedge clk_sys);
      chk({16'h0, updnFreq}, 32'h0);
      sw(5'h01);
      repeat (STEP * 2) @(posedge clk_sys);
      // Clear must win over a still active up terminal
      sw(5'h05);
      chk({16'h0, updnFreq}, 32'h0);
      sw(5'h09);
      repeat (STEP * 3) @(posedge clk_sys);
      rdChk(OFS_UPDN, 32'h0);
      sw(5'h00);
      $display("t_updn done");
   endtask
   task automatic t_src();
      logic [4:0] pat [5] = '{5'h4, 5'h6, 5'h7, 5'h2, 5'h0};
      logic [1:0] ex [5] = '{2'h2, 2'h1, 2'h0, 2'h1, 2'h1};
      fnAll({10'h0, FN_SRC_COMM, FN_SRC_TERM, FN_SRC_KEYPAD});
      for (int i = 0; i < 5; i++) begin
         sw(pat[i]);
         chk({30'h0, cmdSource}, {30'h0, ex[i]});
      end
      rdChk(OFS_STATUS, 32'h00080000);
      rdChk(8'h40, 32'h0);
      $display("t_src done");
   endtask
   task automatic end_of_test();
      $display("tests=%0d fails=%0d", nTests, fails);
      if (fails == 0 && nTests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Whole run is a few hundred cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 8000) begin
         fails++;
         end_of_test();
      end
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      rdChk(OFS_STATUS, 32'h0);
      t_stage();
      t_ramp_pid();
      t_count();
      t_brake();
      t_updn();
      t_src();
      end_of_test();
   end
endmodule
bind input_terminal_function_decoder terminal_decoder_checker i_chk (
   .clk_sys(clk_sys), .resetn(resetn), .decelerating(decelerating), .regAddr(regAddr),
   .regRd(regRd), .regWr(regWr), .regRdata(regRdata), .speedStage(speedStage),
   .pulseCount(pulseCount), .rampFreeze(rampFreeze), .dcBrakeNow(dcBrakeNow),
   .updnFreq(updnFreq), .cmdSource(cmdSource));
